// *** design/ebct_bus_timing.sv ***
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "ebct_defines.svh"
module ebct_bus_timing
   import ebct_pkg::*;
#(
   parameter int AW      = 16,
   parameter int DW      = 16,
   parameter int TCL_CYC = `EBCT_TCL_CYC
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          s_axi_awvalid,
   output wire logic          s_axi_awready,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic [2:0]    s_axi_awprot,
   input  wire logic          s_axi_wvalid,
   output wire logic          s_axi_wready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   output wire logic          s_axi_bvalid,
   input  wire logic          s_axi_bready,
   output wire logic [1:0]    s_axi_bresp,
   input  wire logic          s_axi_arvalid,
   output wire logic          s_axi_arready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic [2:0]    s_axi_arprot,
   output wire logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output wire logic [31:0]   s_axi_rdata,
   output wire logic [1:0]    s_axi_rresp,
   output wire logic          bus_clock_output,
   output wire logic          addr_latch,
   output wire logic          read_chip_select_n,
   output wire logic          write_chip_select_n,
   output wire logic [AW-1:0] addr_out,
   output wire logic [DW-1:0] data_out,
   output wire logic          data_oe_n,
   input  wire logic [DW-1:0] data_in,
   input  wire logic          ready_n
);

   localparam int TW = (TCL_CYC > 1) ? $clog2(TCL_CYC) : 1;

   // Elaboration checks
   if (TCL_CYC < 1) begin : g_chk_tcl
      $error("TCL_CYC must be at least one");
   end
   if (DW < AW || DW > 32 || AW > 32) begin : g_chk_w
      $error("Need AW <= DW <= 32");
   end

   typedef struct packed {
      ebct_phase_t   ph;
      logic [7:0]    cnt;
      logic [TW-1:0] half_clock_unit;
      logic          go;
      logic          req_wr;
      logic          wr;
      logic          done;
      ebct_cfg_t     cfg;
      ebct_cfg_t     cur;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW-1:0] rdata;
      logic          bclk;
      logic          ale;
      logic          rd_n;
      logic          wr_n;
      logic [AW-1:0] a_out;
      logic [DW-1:0] d_out;
      logic          d_oen;
      logic          awready;
      logic          wready;
      logic          aw_got;
      logic          w_got;
      logic [7:0]    awaddr;
      logic [31:0]   wd;
      logic [3:0]    ws;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rd;
      logic [1:0]    rresp;
   } ebct_st_t;

   ebct_st_t     q, d;
   ebct_sync_if #(.DW(DW)) sync ();

   ebct_pin_sync #(.DW(DW)) u_sync (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ready_n_pin (ready_n),
      .data_pin    (data_in),
      .sync        (sync.prod)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Register select from a byte address; misaligned or unknown is unmapped
   function automatic ebct_sel_t reg_sel(input logic [7:0] a);
      unique case (a)
         `EBCT_OFS_CFG:   reg_sel = EBCT_SEL_CFG;
         `EBCT_OFS_ADDR:  reg_sel = EBCT_SEL_ADDR;
         `EBCT_OFS_WDATA: reg_sel = EBCT_SEL_WDATA;
         `EBCT_OFS_CMD:   reg_sel = EBCT_SEL_CMD;
         `EBCT_OFS_RDATA: reg_sel = EBCT_SEL_RDATA;
         default:         reg_sel = EBCT_SEL_NONE;
      endcase
   endfunction : reg_sel

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                         input logic [3:0] s);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[i*8 +: 8] = v[i*8 +: 8];
         end
      end
   endfunction : merge

   // Phase length in half-clock units, minus one, for the counter
   function automatic logic [7:0] phase_cnt(input ebct_phase_t p, input ebct_cfg_t c);
      logic [7:0] ta;
      logic [7:0] tc;
      logic [7:0] tf;
      ta = {7'd0, c.ext};
      tc = 8'((`EBCT_WAIT_MAX - {4'd0, c.wait_cnt}) << 1);
      tf = 8'((`EBCT_TRI_MAX - {7'd0, c.tri_ctl}) << 1);
      unique case (p)
         EBCT_PH_LATCH:  phase_cnt = (c.mux ? `EBCT_MUX_LATCH : `EBCT_DMX_LATCH) + ta - 8'd1;
         EBCT_PH_GAP:    phase_cnt = `EBCT_GAP_LEN - 8'd1;
         EBCT_PH_STROBE: phase_cnt = `EBCT_STROBE_LEN + ta + tc - 8'd1;
         EBCT_PH_FLOAT:  phase_cnt = `EBCT_FLOAT_LEN + tf - 8'd1;
         default:        phase_cnt = 8'd0;
      endcase
   endfunction : phase_cnt

   ////////////////////////////////////////////////////////////////////////////
   // Next state: register bus first, then the bus cycle, so done-set wins
   always_comb begin
      logic      tick;
      logic      fin;
      logic      to_strobe;
      logic      pend;
      logic [31:0] m;
      ebct_sel_t sel;
      d         = q;
      tick      = (q.half_clock_unit == '0);
      fin       = 1'b0;
      to_strobe = 1'b0;
      pend      = q.go || (q.ph != EBCT_PH_IDLE);
      m         = '0;
      sel       = EBCT_SEL_NONE;

      // Half-clock tick generator and bus clock
      d.half_clock_unit = tick ? TW'(TCL_CYC - 1) : q.half_clock_unit - 1'b1;
      if (tick) begin
         d.bclk = ~q.bclk;
      end

      // Write address and data are taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         d.wd    = s_axi_wdata;
         d.ws    = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         sel      = reg_sel(q.awaddr);
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = (sel == EBCT_SEL_NONE) ? `EBCT_RESP_SLVERR : `EBCT_RESP_OKAY;
         unique case (sel)
            EBCT_SEL_CFG: begin
               m     = merge({24'd0, q.cfg}, q.wd, q.ws);
               d.cfg = m[7:0];
            end
            EBCT_SEL_ADDR: begin
               m      = merge(32'(q.addr), q.wd, q.ws);
               d.addr = m[AW-1:0];
            end
            EBCT_SEL_WDATA: begin
               m       = merge(32'(q.wdata), q.wd, q.ws);
               d.wdata = m[DW-1:0];
            end
            EBCT_SEL_CMD: begin
               // A start while busy is dropped; status shows busy
               if (q.ws[0] && q.wd[`EBCT_CMD_CLRDONE]) begin
                  d.done = 1'b0;
               end
               if (q.ws[0] && q.wd[`EBCT_CMD_START] && !pend) begin
                  d.go     = 1'b1;
                  d.req_wr = q.wd[`EBCT_CMD_WRITE];
               end
            end
            EBCT_SEL_RDATA: begin
            end
            EBCT_SEL_NONE: begin
            end
         endcase
      end

      // Read channel
      if (s_axi_rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = `EBCT_RESP_OKAY;
         unique case (reg_sel(s_axi_araddr))
            EBCT_SEL_CFG:   d.rd = {24'd0, q.cfg};
            EBCT_SEL_ADDR:  d.rd = 32'(q.addr);
            EBCT_SEL_WDATA: d.rd = 32'(q.wdata);
            EBCT_SEL_CMD:   d.rd = {30'd0, q.done, pend};
            EBCT_SEL_RDATA: d.rd = 32'(q.rdata);
            EBCT_SEL_NONE: begin
               d.rd    = '0;
               d.rresp = `EBCT_RESP_SLVERR;
            end
         endcase
      end

      // Phase counter steps once per half-clock unit
      if (tick && q.cnt != 8'd0) begin
         d.cnt = q.cnt - 8'd1;
      end

      // Bus cycle sequencer
      unique case (q.ph)
         EBCT_PH_IDLE: begin
            if (tick && q.go) begin
               d.go    = 1'b0;
               d.cur   = q.cfg;
               d.wr    = q.req_wr;
               d.ph    = EBCT_PH_LATCH;
               d.cnt   = phase_cnt(EBCT_PH_LATCH, q.cfg);
               d.ale   = 1'b1;
               d.a_out = q.addr;
               if (q.cfg.mux) begin
                  d.d_out = DW'(q.addr);
                  d.d_oen = 1'b0;
               end
            end
         end
         EBCT_PH_LATCH: begin
            if (tick && q.cnt == 8'd0) begin
               d.ale = 1'b0;
               if (q.cur.mux) begin
                  // Address/data turnaround slot of the multiplexed bus
                  d.ph    = EBCT_PH_GAP;
                  d.cnt   = phase_cnt(EBCT_PH_GAP, q.cur);
                  d.d_oen = ~q.wr;
                  d.d_out = q.wdata;
               end else begin
                  to_strobe = 1'b1;
               end
            end
         end
         EBCT_PH_GAP: begin
            if (tick && q.cnt == 8'd0) begin
               to_strobe = 1'b1;
            end
         end
         EBCT_PH_STROBE: begin
            if (tick && q.cnt == 8'd0) begin
               // Ready is only looked at once the waitstates are spent
               if (q.cur.rdy_en && sync.ready_n_s) begin
                  d.ph = EBCT_PH_READY;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         EBCT_PH_READY: begin
            if (tick && !sync.ready_n_s) begin
               fin = 1'b1;
            end
         end
         EBCT_PH_FLOAT: begin
            if (tick && q.cnt == 8'd0) begin
               d.ph    = EBCT_PH_IDLE;
               d.d_oen = 1'b1;
               d.done  = 1'b1;
            end
         end
      endcase

      if (to_strobe) begin
         d.ph    = EBCT_PH_STROBE;
         d.cnt   = phase_cnt(EBCT_PH_STROBE, q.cur);
         d.rd_n  = q.wr;
         d.wr_n  = ~q.wr;
         d.d_oen = ~q.wr;
         d.d_out = q.wdata;
      end

      // Strobe rise, address change and read capture share one edge
      if (fin) begin
         d.ph    = EBCT_PH_FLOAT;
         d.cnt   = phase_cnt(EBCT_PH_FLOAT, q.cur);
         d.rd_n  = 1'b1;
         d.wr_n  = 1'b1;
         d.a_out = '0;
         if (!q.wr) begin
            d.rdata = sync.data_s;
         end
      end

      // Ready outputs follow the registered channel state
      d.awready = ~d.aw_got & ~d.bvalid;
      d.wready  = ~d.w_got & ~d.bvalid;
      d.arready = ~d.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q       <= '0;
         q.ph    <= EBCT_PH_IDLE;
         q.cfg   <= `EBCT_CFG_RST;
         q.cur   <= `EBCT_CFG_RST;
         q.rd_n  <= 1'b1;
         q.wr_n  <= 1'b1;
         q.d_oen <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign s_axi_awready       = q.awready;
   assign s_axi_wready        = q.wready;
   assign s_axi_bvalid        = q.bvalid;
   assign s_axi_bresp         = q.bresp;
   assign s_axi_arready       = q.arready;
   assign s_axi_rvalid        = q.rvalid;
   assign s_axi_rdata         = q.rd;
   assign s_axi_rresp         = q.rresp;
   assign bus_clock_output    = q.bclk;
   assign addr_latch          = q.ale;
   assign read_chip_select_n  = q.rd_n;
   assign write_chip_select_n = q.wr_n;
   assign addr_out            = q.a_out;
   assign data_out            = q.d_out;
   assign data_oe_n           = q.d_oen;

endmodule : ebct_bus_timing

// *** design/ebct_defines.svh ***
// Notes on behaviour
// - Every step waits on a half-clock tick
// - Multiplexed cycle: six units plus extensions
// - Demultiplexed cycle: four units plus extensions
// - Latch phase grows by extension setting
// - Waitstates are two units times fifteen-minus-field
// - Tristate adds two units unless bit set
// - Settings are snapshot for the next cycle
// - Read data caught when strobe rises
`ifndef EBCT_DEFINES_SVH
`define EBCT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define EBCT_OFS_CFG      8'h00
`define EBCT_OFS_ADDR     8'h04
`define EBCT_OFS_WDATA    8'h08
`define EBCT_OFS_CMD      8'h0C
`define EBCT_OFS_RDATA    8'h10

// Command and status bit positions
`define EBCT_CMD_START    0
`define EBCT_CMD_WRITE    1
`define EBCT_CMD_CLRDONE  2
`define EBCT_STA_BUSY     0
`define EBCT_STA_DONE     1

// Configuration reset value: demux, no extension, field 15, tristate bit set
`define EBCT_CFG_RST      8'h7C

// Cycle length pieces in half-clock units
`define EBCT_MUX_LATCH    8'h02
`define EBCT_DMX_LATCH    8'h01
`define EBCT_GAP_LEN      8'h01
`define EBCT_STROBE_LEN   8'h02
`define EBCT_FLOAT_LEN    8'h01
`define EBCT_WAIT_MAX     8'h0F
`define EBCT_TRI_MAX      8'h01

// Timing: half-clock unit against the 100 MHz system clock
`define EBCT_CLK_NS       10
`define EBCT_TCL_NS       10
`define EBCT_TCL_CYC      ((`EBCT_TCL_NS + `EBCT_CLK_NS - 1) / `EBCT_CLK_NS)

// AXI responses
`define EBCT_RESP_OKAY    2'b00
`define EBCT_RESP_SLVERR  2'b10

`endif

// *** design/ebct_pin_sync.sv ***
`timescale 1ns/10ps
module ebct_pin_sync
   import ebct_pkg::*;
#(
   parameter int DW = 16
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ready_n_pin,
   input  wire logic [DW-1:0] data_pin,
   ebct_sync_if.prod          sync
);

   typedef struct packed {
      logic          rdy1;
      logic          rdy2;
      logic [DW-1:0] dat1;
      logic [DW-1:0] dat2;
   } ebct_sync_st_t;

   ebct_sync_st_t q, d;

   // Two stages; the first stage feeds only the second
   always_comb begin
      d      = q;
      d.rdy1 = ready_n_pin;
      d.rdy2 = q.rdy1;
      d.dat1 = data_pin;
      d.dat2 = q.dat1;
   end

   // Ready idles high (not ready) so reset never looks like a ready pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q      <= '0;
         q.rdy1 <= 1'b1;
         q.rdy2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sync.ready_n_s = q.rdy2;
   assign sync.data_s    = q.dat2;

endmodule : ebct_pin_sync

// *** design/ebct_pkg.sv ***
package ebct_pkg;

   // Bus cycle phases
   typedef enum logic [2:0] {
      EBCT_PH_IDLE,
      EBCT_PH_LATCH,
      EBCT_PH_GAP,
      EBCT_PH_STROBE,
      EBCT_PH_READY,
      EBCT_PH_FLOAT
   } ebct_phase_t;

   // Bus configuration fields, low to high: mux, ext, wait_cnt, tri_ctl, rdy_en
   typedef struct packed {
      logic       rdy_en;
      logic       tri_ctl;
      logic [3:0] wait_cnt;
      logic       ext;
      logic       mux;
   } ebct_cfg_t;

   // Register select codes
   typedef enum logic [2:0] {
      EBCT_SEL_CFG,
      EBCT_SEL_ADDR,
      EBCT_SEL_WDATA,
      EBCT_SEL_CMD,
      EBCT_SEL_RDATA,
      EBCT_SEL_NONE
   } ebct_sel_t;

endpackage : ebct_pkg

// *** design/ebct_sync_if.sv ***
`timescale 1ns/10ps
interface ebct_sync_if #(parameter int DW = 16);
   logic          ready_n_s;
   logic [DW-1:0] data_s;
   modport prod (output ready_n_s, output data_s);
   modport cons (input ready_n_s, input data_s);
endinterface : ebct_sync_if

// *** tb/ebct_bus_timing_props.sv ***
`timescale 1ns/10ps
module ebct_bus_timing_props #(
   parameter int AW = 16
) (
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          bus_clock_output,
   input wire logic          addr_latch,
   input wire logic          read_chip_select_n,
   input wire logic          write_chip_select_n,
   input wire logic [AW-1:0] addr_out,
   input wire logic          data_oe_n
);
   // Low while either strobe is active
   wire any_stb_n = read_chip_select_n & write_chip_select_n;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Bus clock checked only once the reset values have flushed out
   property p_bclk; $past(aresetn, 3) |-> bus_clock_output != $past(bus_clock_output);
   endproperty
   a_bclk: assert property (p_bclk) else $error("bus clock missed a toggle");
   property p_excl; read_chip_select_n || write_chip_select_n;
   endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_quiet; addr_latch |-> any_stb_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("strobe during latch");
   property p_gap; $fell(addr_latch) |-> ##[0:1] !any_stb_n;
   endproperty
   a_gap: assert property (p_gap) else $error("strobe late after latch");
   property p_latch; $rose(addr_latch) |-> ##[1:3] !addr_latch;
   endproperty
   a_latch: assert property (p_latch) else $error("latch phase too long");
   property p_stb_min; $fell(any_stb_n) |-> !any_stb_n [*2];
   endproperty
   a_stb_min: assert property (p_stb_min) else $error("strobe too short");
   property p_rd_float; !read_chip_select_n |-> data_oe_n;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("driving during read");
   property p_wr_drive; !write_chip_select_n |-> !data_oe_n;
   endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
   property p_addr_hold; !any_stb_n && $past(!any_stb_n) |-> $stable(addr_out);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
   property p_addr_drop; $rose(any_stb_n) |-> addr_out == '0;
   endproperty
   a_addr_drop: assert property (p_addr_drop) else $error("address kept after strobe");
   c_rd: cover property ($fell(read_chip_select_n));
   c_wr: cover property ($fell(write_chip_select_n));
   c_long: cover property (!any_stb_n [*6]);
endmodule : ebct_bus_timing_props

// *** tb/ebct_mem_model.sv ***
`timescale 1ns/10ps
module ebct_mem_model #(
   parameter int DW = 16
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [DW-1:0] addr_out,
   input  wire logic [DW-1:0] data_out,
   input  wire logic          data_oe_n,
   input  wire logic          read_chip_select_n,
   input  wire logic          write_chip_select_n,
   input  wire logic [3:0]    stall,
   output wire logic [DW-1:0] data_in,
   output wire logic          ready_n,
   output wire logic [DW-1:0] wr_addr,
   output wire logic [DW-1:0] wr_data
);
   logic [DW-1:0] last_q, wa_q, wd_q;
   logic [3:0]    cnt_q;
   logic          rdy_n_q;
   wire           stb_n = read_chip_select_n & write_chip_select_n;
   // Device drive wins; a floating bus shows a changing pattern, not stale data
   assign data_in = !data_oe_n ? data_out : (addr_out != '0) ? addr_out ^ 16'h5A3C : ~last_q;
   assign ready_n = rdy_n_q;
   assign wr_addr = wa_q;
   assign wr_data = wd_q;
   // Ready held low until the strobe ends, then released at once
   always_ff @(posedge aclk) begin
      last_q <= aresetn ? data_in : '0;
      if (!aresetn) begin
         rdy_n_q <= 1'b1;
         cnt_q   <= 4'h0;
      end else if (!stb_n) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q + 4'h1 >= stall) rdy_n_q <= 1'b0;
      end else begin
         cnt_q   <= 4'h0;
         rdy_n_q <= 1'b1;
      end
      if (!write_chip_select_n) begin
         wa_q <= addr_out;
         wd_q <= data_out;
      end
   end
endmodule : ebct_mem_model

// *** tb/tb_external_bus_cycle_timing.sv ***
`timescale 1ns/10ps
module tb_external_bus_cycle_timing
   import ebct_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic        awready, wready, bvalid, arready, rvalid, bclk, ale, rd_n, wr_n, oe_n, rdy_n;
   logic [1:0]  bresp, rresp;
   logic [15:0] addr, dout, din, wa, wd_m;
   logic [3:0]  stall = 4'h0;
   logic        in_cyc = 1'b0, seen = 1'b0, ale_q = 1'b0;
   int          fail_count = 0, cmp_count = 0, lat_n, gap_n, stb_n, flt_n, pls_n;
   always #5 aclk = ~aclk;
   ebct_bus_timing dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .bus_clock_output(bclk), .addr_latch(ale),
      .read_chip_select_n(rd_n), .write_chip_select_n(wr_n), .addr_out(addr), .data_out(dout),
      .data_oe_n(oe_n), .data_in(din), .ready_n(rdy_n));
   ebct_mem_model mem (
      .aclk(aclk), .aresetn(aresetn), .addr_out(addr), .data_out(dout), .data_oe_n(oe_n),
      .read_chip_select_n(rd_n), .write_chip_select_n(wr_n), .stall(stall), .data_in(din),
      .ready_n(rdy_n), .wr_addr(wa), .wr_data(wd_m));
   ////////////////////////////////////////
   // Phase lengths measured at the pins; float is seen as write data still driven
   always @(posedge aclk) begin
      if (ale && !ale_q) pls_n++;
      ale_q = ale;
      if (ale) begin
         lat_n++;
         in_cyc = 1'b1;
      end else if (!rd_n || !wr_n) begin
         stb_n++;
         seen = 1'b1;
      end else if (seen && !oe_n) flt_n++;
      else if (in_cyc && !seen) gap_n++;
   end
   task automatic clr();
      {lat_n, gap_n, stb_n, flt_n, pls_n} = '0;
      {in_cyc, seen} = 2'b00;
   endtask : clr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bus master: hold each channel until taken, hold ready until the answer
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   // Settings for pass i: every mux, extension, tristate and ready mix
   function automatic ebct_cfg_t mk(input int i);
      ebct_cfg_t c;
      c.rdy_en   = i[3];
      c.tri_ctl  = i[2];
      c.wait_cnt = (i == 16) ? 4'h0 : 4'($urandom_range(15, 12));
      c.ext      = i[1];
      c.mux      = i[0];
      return c;
   endfunction : mk
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////
   initial begin
      #400_000;
      fail_count++;
      end_sim();
   end
   // Main sequence; the next settings are written while each cycle runs
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      ebct_cfg_t   c, n;
      logic [15:0] a, w;
      logic        wr;
      int          e;
      void'($urandom(25));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, d, r);
      chk(d, 32'h0000_007C);
      rd(8'h14, d, r);
      chk(d, 32'h0000_0000);
      chk(r, 32'h0000_0002);
      axw(8'h14, 32'hFFFF_FFFF, r);
      chk(r, 32'h0000_0002);
      c = mk(0);
      axw(8'h00, {24'h00_0000, c}, r);
      for (int i = 0; i < 17; i++) begin
         a = 16'($urandom) | 16'h0001;
         w = 16'($urandom);
         wr = i[0] ^ i[1];
         stall <= 4'($urandom_range(9, 4));
         axw(8'h04, {16'h0000, a}, r);
         axw(8'h08, {16'h0000, w}, r);
         clr();
         axw(8'h0C, {30'h0000_0000, wr, 1'b1}, r);
         n = mk(i + 1);
         axw(8'h00, {24'h00_0000, n}, r);
         if (i == 16) axw(8'h0C, 32'h0000_0001, r);
         do rd(8'h0C, d, r); while (d[0] !== 1'b0);
         chk(d, 32'h0000_0002);
         chk(pls_n, 1);
         chk(lat_n, (c.mux ? 2 : 1) + c.ext);
         chk(gap_n, c.mux);
         e = 2 + c.ext + 2 * (15 - c.wait_cnt);
         if (c.rdy_en) begin
            chk(32'(stb_n >= e && stb_n > stall && stb_n <= ((e > stall + 4) ? e : stall + 4)), 1);
         end else begin
            chk(stb_n, e);
         end
         chk(flt_n, wr ? 1 + 2 * (1 - c.tri_ctl) : 0);
         // Ready stretches the strobe, so only the programmed part is summed then
         chk(lat_n + gap_n + (c.rdy_en ? e : stb_n), e + 1 + c.ext + 2 * c.mux);
         if (wr) begin
            chk(wa, a);
            chk(wd_m, w);
         end else begin
            rd(8'h10, d, r);
            chk(d, {16'h0000, a ^ 16'h5A3C});
         end
         axw(8'h0C, 32'h0000_0004, r);
         rd(8'h0C, d, r);
         chk(d, 32'h0000_0000);
         c = n;
      end
      end_sim();
   end
endmodule : tb_external_bus_cycle_timing
bind ebct_bus_timing ebct_bus_timing_props #(.AW(AW)) u_props (.aclk(aclk), .aresetn(aresetn),
   .bus_clock_output(bus_clock_output), .addr_latch(addr_latch),
   .read_chip_select_n(read_chip_select_n), .write_chip_select_n(write_chip_select_n),
   .addr_out(addr_out), .data_oe_n(data_oe_n));
